// ---- logic/dbg_gpio.sv ----
`timescale 1ns/1ns
`default_nettype none
module dbg_gpio
    import dbg_pkg::*;
#(
    parameter bit LARGE_PKG = 1'b1,
    parameter int W         = DBG_PORT_W
)(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output var  logic [31:0]  prdata,
    output var  logic         pready,
    output var  logic         pslverr,
    input  wire logic [W-1:0] hport_pin_in,
    output var  logic [W-1:0] hport_pin_out,
    output var  logic [W-1:0] hport_pin_oe_n,
    input  wire logic [W-1:0] jport_pin_in,
    output var  logic [W-1:0] jport_pin_out,
    output var  logic [W-1:0] jport_pin_oe_n,
    output var  logic [W-1:0] hport_seg_claim,
    output var  logic [W-1:0] jport_seg_claim,
    output var  logic [W-1:0] jport_pullup_on
);
    logic [7:0]  seg_bank5_reg;      // segment enables 47..40
    logic [7:0]  seg_bank4_reg;      // segment enables 39..32
    logic        jpu_reg;            // global j pull-up enable
    logic [W-1:0] h_latch, h_dir, h_level;
    logic [W-1:0] j_latch, j_dir, j_level;
    logic [W-1:0] h_seg, j_seg;
    logic        wr_ok;              // write access phase
    logic        h_wr_latch;         // port h latch load, from level or latch offset
    logic        h_wr_dir;           // port h direction load
    logic        j_wr_latch;         // port j latch load, from level or latch offset
    logic        j_wr_dir;           // port j direction load
    logic        addr_hit;           // mapped offset
    logic [31:0] rdata_next;
    dbg_apb_state_t state_reg;

    // decode one offset; used by every register
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // mapped set shrinks in the small package
    always_comb
    begin
        addr_hit = hit(paddr, DBG_OFF_GPORT_PIN);
        if (LARGE_PKG)
            addr_hit = addr_hit
                | hit(paddr, DBG_OFF_HPORT_PIN) | hit(paddr, DBG_OFF_HPORT_LATCH)
                | hit(paddr, DBG_OFF_HPORT_DIR) | hit(paddr, DBG_OFF_SEG_BANK5)
                | hit(paddr, DBG_OFF_JPORT_PIN) | hit(paddr, DBG_OFF_JPORT_LATCH)
                | hit(paddr, DBG_OFF_JPORT_DIR) | hit(paddr, DBG_OFF_SEG_BANK4);
    end

    assign wr_ok = psel & penable & pwrite & (state_reg == DBG_ACCESS);

    // write strobes per port register; a level write loads the latch, never the pads
    assign h_wr_latch = wr_ok & LARGE_PKG
                      & (hit(paddr, DBG_OFF_HPORT_PIN) | hit(paddr, DBG_OFF_HPORT_LATCH));
    assign h_wr_dir   = wr_ok & LARGE_PKG & hit(paddr, DBG_OFF_HPORT_DIR);
    assign j_wr_latch = wr_ok & LARGE_PKG
                      & (hit(paddr, DBG_OFF_JPORT_PIN) | hit(paddr, DBG_OFF_JPORT_LATCH));
    assign j_wr_dir   = wr_ok & LARGE_PKG & hit(paddr, DBG_OFF_JPORT_DIR);

    // apb phase tracker: ready on the second cycle of each transfer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_reg <= DBG_IDLE;
        else
        begin
            case (state_reg)
                DBG_IDLE:   if (psel && !penable) state_reg <= DBG_ACCESS;
                DBG_ACCESS: state_reg <= DBG_IDLE;
                default:    state_reg <= DBG_IDLE;
            endcase
        end
    end

    // pready registered, high for the access cycle; pslverr registered, high then only for an unmapped offset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~addr_hit;
        end
    end

    // segment banks and pull-up control
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            seg_bank5_reg <= DBG_RST_SEG;
            seg_bank4_reg <= DBG_RST_SEG;
            jpu_reg       <= DBG_RST_PULLUP;
        end
        else if (wr_ok && addr_hit)
        begin
            if (hit(paddr, DBG_OFF_SEG_BANK5))
                seg_bank5_reg <= pwdata[7:0];
            else if (hit(paddr, DBG_OFF_SEG_BANK4))
                seg_bank4_reg <= pwdata[7:0];
            else if (hit(paddr, DBG_OFF_GPORT_PIN) && LARGE_PKG)
                jpu_reg <= pwdata[DBG_JPULLUP_BIT];
        end
    end

    // segment to pin mapping, fixed wiring
    always_comb
    begin
        h_seg = {seg_bank5_reg[3:0], seg_bank5_reg[4], seg_bank5_reg[5],
                 seg_bank5_reg[6], seg_bank5_reg[7]};
        j_seg = {seg_bank4_reg[4], seg_bank4_reg[5], seg_bank4_reg[6],
                 seg_bank4_reg[7], seg_bank4_reg[3:1], 1'b0};
        if (!LARGE_PKG)
        begin
            h_seg = '0;
            j_seg = '0;
        end
    end

    // port h: level or latch writes both load the latch
    dbg_port #(.W(W)) u_hport (
        .pclk     (pclk),
        .presetn  (presetn),
        .wr_latch (h_wr_latch),
        .wr_dir   (h_wr_dir),
        .wdata    (pwdata[W-1:0]),
        .seg_en   (h_seg),
        .pin_in   (hport_pin_in),
        .latch_q  (h_latch),
        .dir_q    (h_dir),
        .level_q  (h_level),
        .pin_out  (hport_pin_out),
        .pin_oe_n (hport_pin_oe_n)
    );

    // port j: directions reset to inputs
    dbg_port #(.W(W)) u_jport (
        .pclk     (pclk),
        .presetn  (presetn),
        .wr_latch (j_wr_latch),
        .wr_dir   (j_wr_dir),
        .wdata    (pwdata[W-1:0]),
        .seg_en   (j_seg),
        .pin_in   (jport_pin_in),
        .latch_q  (j_latch),
        .dir_q    (j_dir),
        .level_q  (j_level),
        .pin_out  (jport_pin_out),
        .pin_oe_n (jport_pin_oe_n)
    );

    // pull-up on per pin only as input, not claimed by a segment
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            jport_pullup_on <= '0;
        else
            jport_pullup_on <= {W{jpu_reg}} & j_dir & ~j_seg;
    end

    // segment claims exported to the lcd driver
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hport_seg_claim <= '0;
            jport_seg_claim <= '0;
        end
        else
        begin
            hport_seg_claim <= h_seg;
            jport_seg_claim <= j_seg;
        end
    end

    // read mux; overrides never alter the stored values
    always_comb
    begin
        rdata_next = 32'h0000_0000;
        if (hit(paddr, DBG_OFF_GPORT_PIN))
            rdata_next[DBG_JPULLUP_BIT] = jpu_reg & LARGE_PKG;
        else if (!LARGE_PKG)
            rdata_next = 32'h0000_0000;
        else if (hit(paddr, DBG_OFF_HPORT_PIN))
            rdata_next[W-1:0] = h_level;
        else if (hit(paddr, DBG_OFF_HPORT_LATCH))
            rdata_next[W-1:0] = h_latch;
        else if (hit(paddr, DBG_OFF_HPORT_DIR))
            rdata_next[W-1:0] = h_dir;
        else if (hit(paddr, DBG_OFF_SEG_BANK5))
            rdata_next[7:0] = seg_bank5_reg;
        else if (hit(paddr, DBG_OFF_JPORT_PIN))
            rdata_next[W-1:0] = j_level;
        else if (hit(paddr, DBG_OFF_JPORT_LATCH))
            rdata_next[W-1:0] = j_latch;
        else if (hit(paddr, DBG_OFF_JPORT_DIR))
            rdata_next[W-1:0] = j_dir;
        else if (hit(paddr, DBG_OFF_SEG_BANK4))
            rdata_next[7:0] = seg_bank4_reg;
    end

    // read data registered in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata <= rdata_next;
    end

    // apb handshake steps: one setup cycle, then exactly one ready cycle
    sequence s_apb_setup;
        psel && !penable;
    endsequence
    sequence s_ready_once;
        pready ##1 !pready;
    endsequence

    // reset leaves every j pin an input
    a_jdir_reset_in: assert property (@(posedge pclk) $rose(presetn) |-> j_dir == 8'hFF)
        else $error("j direction not all inputs after reset");

    // an output pin never keeps its pull-up
    a_pullup_out_off: assert property (
        @(posedge pclk) disable iff (!presetn) !j_dir[2] |=> !jport_pullup_on[2])
        else $error("pull-up on for output pin");

    // a claimed pin is released by the port
    a_seg_releases: assert property (
        @(posedge pclk) disable iff (!presetn) h_seg[0] |=> hport_pin_oe_n[0])
        else $error("segment pin still driven");

    // exported claims follow the h segment wiring
    a_h0_segment_line_47: assert property (
        @(posedge pclk) disable iff (!presetn) LARGE_PKG
        |=> hport_seg_claim[0] == $past(seg_bank5_reg[7]) && hport_seg_claim[4] == $past(seg_bank5_reg[0]))
        else $error("port h segment map wrong");

    // j pin 0 never claimed, pin 1 follows its enable
    a_j0_noseg: assert property (
        @(posedge pclk) disable iff (!presetn) LARGE_PKG
        |=> !jport_seg_claim[0] && jport_seg_claim[1] == $past(seg_bank4_reg[1]))
        else $error("port j pin 0 claimed");

    // one ready cycle per setup, no wait states
    a_ready_pulse: assert property (
        @(posedge pclk) disable iff (!presetn) s_apb_setup |=> s_ready_once)
        else $error("pready not one cycle");

    // free output pin is driven from the latch
    a_out_drive: assert property (
        @(posedge pclk) disable iff (!presetn) (!h_seg[1] && !h_dir[1])
        |=> !hport_pin_oe_n[1] && hport_pin_out[1] == $past(h_latch[1]))
        else $error("output pin not driven from latch");

    // global bit off forces every pull-up off
    a_pullup_global: assert property (
        @(posedge pclk) disable iff (!presetn) !jpu_reg |=> jport_pullup_on == '0)
        else $error("pull-ups on with global off");

    // directions change only by a bus write, never by an override
    a_dir_no_writeback: assert property (
        @(posedge pclk) disable iff (!presetn) !wr_ok |=> $stable(h_dir) && $stable(j_dir))
        else $error("direction changed without a write");

    // a level write lands in the latch
    a_pin_write_latch: assert property (
        @(posedge pclk) disable iff (!presetn) LARGE_PKG && wr_ok && hit(paddr, DBG_OFF_HPORT_PIN)
        |=> h_latch == $past(pwdata[W-1:0]))
        else $error("level write missed the latch");

    // a free input pin gets its pull-up when enabled
    a_pullup_input: assert property (
        @(posedge pclk) disable iff (!presetn) jpu_reg && j_dir[7] && !j_seg[7] |=> jport_pullup_on[7])
        else $error("pull-up missing on input pin");
endmodule // dbg_gpio
`default_nettype wire

// ---- logic/dbg_pin_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
module dbg_pin_sync
    import dbg_pkg::*;
#(
    parameter int W = 8
)(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] pin_async,
    output var  logic [W-1:0] pin_stable
);
    // three stages; only stage1 reads stage0
    logic [W-1:0] stage0_reg;
    logic [W-1:0] stage1_reg;
    logic [W-1:0] stage2_reg;

    // shift chain, no gate on stage0
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stage0_reg <= '0;
            stage1_reg <= '0;
            stage2_reg <= '0;
        end
        else
        begin
            stage0_reg <= pin_async;
            stage1_reg <= stage0_reg;
            stage2_reg <= stage1_reg;
        end
    end

    // a change counts once stages two and three agree
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pin_stable <= '0;
        else if (stage1_reg == stage2_reg)
            pin_stable <= stage2_reg;
    end
endmodule // dbg_pin_sync
`default_nettype wire

// ---- logic/dbg_pkg.sv ----
package dbg_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] DBG_OFF_HPORT_PIN    = 8'h00;
    localparam logic [7:0] DBG_OFF_HPORT_LATCH  = 8'h04;
    localparam logic [7:0] DBG_OFF_HPORT_DIR    = 8'h08;
    localparam logic [7:0] DBG_OFF_SEG_BANK5    = 8'h0C;
    localparam logic [7:0] DBG_OFF_JPORT_PIN    = 8'h10;
    localparam logic [7:0] DBG_OFF_JPORT_LATCH  = 8'h14;
    localparam logic [7:0] DBG_OFF_JPORT_DIR    = 8'h18;
    localparam logic [7:0] DBG_OFF_SEG_BANK4    = 8'h1C;
    localparam logic [7:0] DBG_OFF_GPORT_PIN    = 8'h20;
    // field positions
    localparam int         DBG_JPULLUP_BIT      = 5;
    localparam int         DBG_PORT_W           = 8;
    // reset values
    localparam logic [7:0] DBG_RST_LATCH        = 8'h00;
    localparam logic [7:0] DBG_RST_DIR          = 8'hFF;
    localparam logic [7:0] DBG_RST_SEG          = 8'h00;
    localparam logic       DBG_RST_PULLUP       = 1'b0;
    // pin synchroniser depth
    localparam int         DBG_SYNC_STAGES      = 3;
    // fsm of the apb slave
    typedef enum logic [0:0] {DBG_IDLE, DBG_ACCESS} dbg_apb_state_t;
endpackage

// ---- logic/dbg_port.sv ----
`timescale 1ns/1ns
`default_nettype none
module dbg_port
    import dbg_pkg::*;
#(
    parameter int W = 8
)(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         wr_latch,
    input  wire logic         wr_dir,
    input  wire logic [W-1:0] wdata,
    input  wire logic [W-1:0] seg_en,
    input  wire logic [W-1:0] pin_in,
    output var  logic [W-1:0] latch_q,
    output var  logic [W-1:0] dir_q,
    output var  logic [W-1:0] level_q,
    output var  logic [W-1:0] pin_out,
    output var  logic [W-1:0] pin_oe_n
);
    // direction and latch storage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            latch_q <= DBG_RST_LATCH;
            dir_q   <= DBG_RST_DIR;
        end
        else
        begin
            if (wr_latch)
                latch_q <= wdata;
            if (wr_dir)
                dir_q <= wdata;
        end
    end

    dbg_pin_sync #(.W(W)) u_sync (
        .pclk       (pclk),
        .presetn    (presetn),
        .pin_async  (pin_in),
        .pin_stable (level_q)
    );

    // pad drive per pin; segment takes the pin, oe released
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_out  <= '0;
            pin_oe_n <= '1;
        end
        else
        begin
            for (int i = 0; i < W; i++)
            begin
                pin_out[i]  <= latch_q[i];
                pin_oe_n[i] <= seg_en[i] | dir_q[i];
            end
        end
    end
endmodule // dbg_port
`default_nettype wire

// ---- tb/dbg_pad_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// far side of one port: the pads, as the port, the board and the segment driver leave them
module dbg_pad_model #(
    parameter int W = 8
)(
    input  wire logic         pclk,
    input  wire logic [W-1:0] pin_out,
    input  wire logic [W-1:0] pin_oe_n,
    input  wire logic [W-1:0] seg_claim,
    input  wire logic [W-1:0] pullup_on,
    input  wire logic [W-1:0] ext_val,
    input  wire logic [W-1:0] ext_en,
    output var  logic [W-1:0] pin_in
);
    logic flip = 1'b0; // level of an undriven pad
    // a released pad must not keep its last value, so it wanders every cycle
    always_ff @(posedge pclk)
    begin
        flip <= ~flip;
    end
    // resolve each pad from every party that may drive it
    always_comb
    begin
        for (int i = 0; i < W; i++)
        begin
            if (seg_claim[i])
                pin_in[i] = flip;       // segment waveform, not port data
            else if (!pin_oe_n[i])
                pin_in[i] = pin_out[i]; // port drives its latch
            else if (ext_en[i])
                pin_in[i] = ext_val[i]; // board drives an input
            else if (pullup_on[i])
                pin_in[i] = 1'b1;       // weak pull-up holds high
            else
                pin_in[i] = flip;
        end
    end
endmodule // dbg_pad_model
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import dbg_pkg::*;
;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  h_in, h_out, h_oe_n, j_in, j_out, j_oe_n, h_claim, j_claim, j_pu;
    logic [7:0]  ext_h = 8'h00, ext_en_h = 8'h00, ext_en_j = 8'h00;
    int          n_errors = 0;
    int          comparisons = 0;
    logic [31:0] rd;
    logic        err;
    logic [31:0] prdata_s, rd_s;     // small-package instance on the same bus
    logic        pslverr_s, err_s;
    logic [7:0]  hs_oe_n, js_oe_n, hs_claim, js_claim, js_pu;

    // 25 MHz core clock
    always #20 pclk = ~pclk;

    dbg_gpio i_dbg_gpio (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hport_pin_in(h_in), .hport_pin_out(h_out), .hport_pin_oe_n(h_oe_n),
        .jport_pin_in(j_in), .jport_pin_out(j_out), .jport_pin_oe_n(j_oe_n),
        .hport_seg_claim(h_claim), .jport_seg_claim(j_claim), .jport_pullup_on(j_pu));
    // small package: ports h and j absent, listens to the same bus
    dbg_gpio #(.LARGE_PKG(1'b0)) i_dbg_gpio_small (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_s), .pready(),
        .pslverr(pslverr_s), .hport_pin_in(h_in), .hport_pin_out(), .hport_pin_oe_n(hs_oe_n),
        .jport_pin_in(j_in), .jport_pin_out(), .jport_pin_oe_n(js_oe_n),
        .hport_seg_claim(hs_claim), .jport_seg_claim(js_claim), .jport_pullup_on(js_pu));
    // h port has no pull-ups on its pads
    dbg_pad_model i_dbg_pad_model (.pclk(pclk), .pin_out(h_out), .pin_oe_n(h_oe_n),
        .seg_claim(h_claim), .pullup_on(8'h00), .ext_val(ext_h), .ext_en(ext_en_h), .pin_in(h_in));
    dbg_pad_model i_dbg_pad_model_j (.pclk(pclk), .pin_out(j_out), .pin_oe_n(j_oe_n),
        .seg_claim(j_claim), .pullup_on(j_pu), .ext_val(8'h00), .ext_en(ext_en_j), .pin_in(j_in));

    task automatic finish_test();
        if (n_errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never sees pready
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        rd_s = prdata_s;
        err_s = pslverr_s;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h00_0000, d});
    endtask

    task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(what, {24'h00_0000, exp}, rd);
    endtask

    // pin mask claimed by one segment enable bit of bank5 or bank4
    function automatic logic [7:0] seg_pin(input bit jbank, input int b);
        if (!jbank)
            return 8'h01 << ((b >= 4) ? 7 - b : b + 4);
        if (b == 0)
            return 8'h00;
        return 8'h01 << ((b >= 4) ? 11 - b : b);
    endfunction

    task automatic t_reset();
        rdchk("j dir", DBG_OFF_JPORT_DIR, DBG_RST_DIR);
        check("j oe_n", 8'hFF, j_oe_n);
        apb(1'b0, DBG_OFF_GPORT_PIN, 32'h0000_0000);
        check("g pullup bit", 0, rd & (32'h1 << DBG_JPULLUP_BIT));
        check("j pullup", 0, j_pu);
    endtask

    task automatic t_hport();
        wr(DBG_OFF_HPORT_DIR, 8'h0F);
        wr(DBG_OFF_HPORT_LATCH, 8'hA5);
        ext_h <= 8'h03;
        ext_en_h <= 8'h0F;
        cyc(6);
        check("h oe_n", 8'h0F, h_oe_n);
        check("h drive", 8'hA0, h_out & ~h_oe_n);
        rdchk("h level", DBG_OFF_HPORT_PIN, 8'hA3);
        wr(DBG_OFF_HPORT_PIN, 8'h5A);
        rdchk("h latch", DBG_OFF_HPORT_LATCH, 8'h5A);
    endtask

    task automatic t_segments();
        logic [7:0] m;
        wr(DBG_OFF_HPORT_DIR, 8'h00);
        wr(DBG_OFF_JPORT_DIR, 8'h00);
        for (int b = 0; b < 8; b++)
        begin
            wr(DBG_OFF_SEG_BANK5, 8'h01 << b);
            wr(DBG_OFF_SEG_BANK4, 8'h01 << b);
            cyc(2);
            m = seg_pin(1'b0, b);
            check("h claim", m, h_claim);
            check("h oe_n", m, h_oe_n);
            m = seg_pin(1'b1, b);
            check("j claim", m, j_claim);
            check("j oe_n", m, j_oe_n);
            rdchk("h dir", DBG_OFF_HPORT_DIR, 8'h00);
        end
        wr(DBG_OFF_SEG_BANK5, 8'h00);
        wr(DBG_OFF_SEG_BANK4, 8'h00);
    endtask

    task automatic t_jport();
        wr(DBG_OFF_JPORT_DIR, 8'hF0);
        wr(DBG_OFF_JPORT_LATCH, 8'h3C);
        wr(DBG_OFF_GPORT_PIN, 8'h20);
        cyc(6);
        check("j pullup", 8'hF0, j_pu);
        rdchk("j level", DBG_OFF_JPORT_PIN, 8'hFC);
        wr(DBG_OFF_GPORT_PIN, 8'h00);
        cyc(2);
        check("j pullup off", 0, j_pu);
    endtask

    task automatic t_unmapped();
        apb(1'b1, 8'h24, 32'h0000_00FF);
        check("wr err", 1, err);
        apb(1'b0, 8'h24, 32'h0000_0000);
        check("rd err", 1, err);
        check("rd data", 0, rd);
    endtask

    // small package: writes land nowhere, h reads give zero and an error
    task automatic t_small();
        wr(DBG_OFF_GPORT_PIN, 8'h20);
        wr(DBG_OFF_SEG_BANK5, 8'hFF);
        wr(DBG_OFF_JPORT_DIR, 8'h00);
        apb(1'b0, DBG_OFF_GPORT_PIN, 32'h0000_0000);
        check("g pullup large", 32'h0000_0020, rd);
        check("g pullup small", 0, rd_s);
        check("small pads", 32'hFFFF_0000, {hs_oe_n, js_oe_n, hs_claim, js_claim});
        check("small pullup", 0, js_pu);
        apb(1'b0, DBG_OFF_HPORT_DIR, 32'h0000_0000);
        check("small h err", 1, err_s);
        check("small h data", 0, rd_s);
        wr(DBG_OFF_SEG_BANK5, 8'h00);
    endtask

    task automatic t_rereset();
        wr(DBG_OFF_JPORT_DIR, 8'h00);
        wr(DBG_OFF_GPORT_PIN, 8'h20);
        presetn <= 1'b0;
        cyc(2);
        presetn <= 1'b1;
        t_reset();
    endtask

    // main sequence
    initial
    begin
        cyc(2);
        presetn <= 1'b1;
        t_reset();
        t_hport();
        t_segments();
        t_jport();
        t_unmapped();
        t_small();
        t_rereset();
        finish_test();
    end

    // watchdog well beyond the 52 transfers above
    initial
    begin
        cyc(5000);
        n_errors++;
        finish_test();
    end
endmodule // tb_top
`default_nettype wire
